// ### shared/srs_pkg.sv
// constants and types shared by both ends of the two-wire register link
package srs_pkg;
  // strap resistor classes, as decoded by the board's strap sensing
  typedef enum logic [2:0] {
    SRS_STRAP_GND  = 3'h0,
    SRS_STRAP_R56  = 3'h1,
    SRS_STRAP_R68  = 3'h2,
    SRS_STRAP_R82  = 3'h3,
    SRS_STRAP_R100 = 3'h4,
    SRS_STRAP_R120 = 3'h5,
    SRS_STRAP_R150 = 3'h6,
    SRS_STRAP_VDD  = 3'h7
  } srs_strap_t;

  typedef enum logic [1:0] {
    SRS_MODE_TWO_WIRE = 2'h0,
    SRS_MODE_SPI4     = 2'h1,
    SRS_MODE_SPI3     = 2'h2,
    SRS_MODE_RSVD     = 2'h3
  } srs_mode_t;

  localparam logic [3:0] SRS_ADDR_PREFIX = 4'h5;
  localparam logic [2:0] SRS_SUFFIX_R82  = 3'h4;
  localparam logic [2:0] SRS_SUFFIX_R100 = 3'h3;
  localparam logic [2:0] SRS_SUFFIX_R120 = 3'h2;
  localparam logic [2:0] SRS_SUFFIX_R150 = 3'h1;
  localparam logic [2:0] SRS_SUFFIX_VDD  = 3'h0;

  typedef enum logic [1:0] {
    SRS_OP_WRITE   = 2'h0,
    SRS_OP_READ    = 2'h1,
    SRS_OP_SET_PTR = 2'h2,
    SRS_OP_RECEIVE = 2'h3
  } srs_op_t;

  localparam int SRS_LINK_CLK_KHZ = 66667;
  localparam int SRS_CORE_CLK_KHZ = 20000;
  localparam int SRS_POWERUP_MS   = 15;
  localparam int SRS_CLK_LOW_MS   = 30;
  localparam int SRS_IDLE_US      = 200;
  localparam int SRS_SCL_KHZ      = 100;

  localparam int SRS_DEV_POWERUP_CYC  = SRS_POWERUP_MS * SRS_LINK_CLK_KHZ;
  localparam int SRS_DEV_CLK_LOW_CYC  = SRS_CLK_LOW_MS * SRS_LINK_CLK_KHZ;
  localparam int SRS_DEV_IDLE_CYC     = (SRS_IDLE_US * SRS_LINK_CLK_KHZ + 999) / 1000;
  localparam int SRS_HOST_POWERUP_CYC = SRS_POWERUP_MS * SRS_CORE_CLK_KHZ;
  localparam int SRS_QTR_CYC          = SRS_CORE_CLK_KHZ / (4 * SRS_SCL_KHZ);

  localparam int SRS_WAIT_W = 22;
  localparam logic [3:0] SRS_BYTE_BITS = 4'h8;
endpackage

// ### shared/srs_link_if.sv
// open-drain two-wire link between the host end and the register slave end
interface srs_link_if;
  logic link_clk;
  logic scl_out_host;
  logic scl_oe_host;
  logic sda_out_host;
  logic sda_oe_host;
  logic sda_out_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // pulled up unless some end drives a low
  assign scl = ~(scl_oe_host & ~scl_out_host);
  assign sda = ~((sda_oe_host & ~sda_out_host) | (sda_oe_dev & ~sda_out_dev));

  modport device (input link_clk, input scl, input sda, output sda_out_dev, output sda_oe_dev);
  modport host (input scl, input sda, output scl_out_host, output scl_oe_host,
                output sda_out_host, output sda_oe_host);
endinterface

// ### src/srs_device.sv
// two-wire register slave end: strap decode, framing, pointer and register port
//
// Overview of operation
// - strap caught at startup; low straps pick serial or reserved modes
// - strap picks one of five 0101xxx addresses
// - serial select pin ignored in two-wire mode
// - bus ignored for 15 ms after power up
// - host may stretch; device never holds clock
// - data fall with clock high starts address
// - first byte is address plus direction bit
// - bytes are eight bits, most significant first
// - device acks its own address, bar deep-sleep bare reads, and every written byte on ninth clock
// - host acknowledges read bytes except the last
// - data rise with clock high returns to idle
// - enabled timeout resets after 30 ms clock low
// - timeout enable comes from software, off after reset
// - enabled idle reset after 200 us both high
// - host clock between 10 kHz and 400 kHz
// - block transfers carry no byte count
// - write byte loads the addressed register
// - read byte uses repeated start then one byte
// - pointer-only write sets pointer, writes nothing
// - bare read returns register at current pointer
// - deep sleep drops bare read support; pointer-only writes still work
// - pointer advances per written or acked read byte, wraps at FFh
module srs_device #(
  parameter int POWERUP_CYC = srs_pkg::SRS_DEV_POWERUP_CYC,
  parameter int CLK_LOW_CYC = srs_pkg::SRS_DEV_CLK_LOW_CYC,
  parameter int IDLE_CYC    = srs_pkg::SRS_DEV_IDLE_CYC
) (
  srs_link_if.device               lnk,
  input  wire logic                reset,
  input  wire srs_pkg::srs_strap_t protocol_strap_pin,
  input  wire logic                timeout_en,
  input  wire logic                deepest_sleep_control,
  input  wire logic [7:0]          reg_rdata,
  output logic [7:0]               reg_addr,
  output logic [7:0]               reg_wdata,
  output logic                     reg_wr,
  output logic                     reg_rd,
  output srs_pkg::srs_mode_t       protocol_mode,
  output logic [6:0]               slave_addr,
  output logic                     link_ready
);
  typedef enum logic [2:0] {
    SRS_D_IDLE = 3'h0,
    SRS_D_ADDR = 3'h1,
    SRS_D_AACK = 3'h3,
    SRS_D_RX   = 3'h2,
    SRS_D_RACK = 3'h6,
    SRS_D_TX   = 3'h7,
    SRS_D_TACK = 3'h5
  } srs_dev_state_t;

  typedef struct packed {
    logic [2:0]                     scl_sy;
    logic [2:0]                     sda_sy;
    logic [3:0]                     cfg_sy;
    srs_dev_state_t                 st;
    logic [3:0]                     bit_cnt;
    logic [7:0]                     sh;
    logic [7:0]                     ptr;
    logic                           ptr_phase;
    logic                           read_ok;
    logic                           rw;
    logic                           acked;
    logic [srs_pkg::SRS_WAIT_W-1:0] wait_cnt;
    logic                           ready;
    logic                           strap_done;
    srs_pkg::srs_mode_t             mode;
    logic [6:0]                     addr;
    logic                           sda_oe;
    logic [7:0]                     wdata;
    logic                           wr;
    logic                           rd;
  } srs_dev_q_t;

  srs_dev_q_t q;
  srs_dev_q_t d;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       clk_low;
  logic       bus_idle;

  always_comb begin
    d        = q;
    // stage [0] feeds only stage [1]; [2] is the previous sample for edges
    d.scl_sy = {q.scl_sy[1:0], lnk.scl};
    d.sda_sy = {q.sda_sy[1:0], lnk.sda};
    d.cfg_sy = {q.cfg_sy[1:0], timeout_en, deepest_sleep_control};
    d.wr     = 1'b0;
    d.rd     = 1'b0;
    rise     = q.scl_sy[1] & ~q.scl_sy[2];
    fall     = ~q.scl_sy[1] & q.scl_sy[2];
    start    = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[2] & ~q.sda_sy[1];
    stop     = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[2] & q.sda_sy[1];
    clk_low  = ~q.scl_sy[1];
    bus_idle = q.scl_sy[1] & q.sda_sy[1];

    // the strap is sensed once, on the first edge after reset release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.addr[6:3]  = srs_pkg::SRS_ADDR_PREFIX;
      d.mode       = srs_pkg::SRS_MODE_TWO_WIRE;
      unique case (protocol_strap_pin)
        srs_pkg::SRS_STRAP_GND:  d.mode = srs_pkg::SRS_MODE_SPI4;
        srs_pkg::SRS_STRAP_R56:  d.mode = srs_pkg::SRS_MODE_SPI3;
        srs_pkg::SRS_STRAP_R68:  d.mode = srs_pkg::SRS_MODE_RSVD;
        srs_pkg::SRS_STRAP_R82:  d.addr[2:0] = srs_pkg::SRS_SUFFIX_R82;
        srs_pkg::SRS_STRAP_R100: d.addr[2:0] = srs_pkg::SRS_SUFFIX_R100;
        srs_pkg::SRS_STRAP_R120: d.addr[2:0] = srs_pkg::SRS_SUFFIX_R120;
        srs_pkg::SRS_STRAP_R150: d.addr[2:0] = srs_pkg::SRS_SUFFIX_R150;
        srs_pkg::SRS_STRAP_VDD:  d.addr[2:0] = srs_pkg::SRS_SUFFIX_VDD;
      endcase
    end

    // a write issued last cycle moves the pointer on, wrapping at FFh
    if (q.wr) begin
      d.ptr = q.ptr + 8'h01;
    end

    if (!q.ready) begin
      // traffic during the power-up window is not even looked at
      d.wait_cnt = q.wait_cnt + 22'h00_0001;
      if (q.wait_cnt == 22'(POWERUP_CYC - 1)) begin
        d.ready    = 1'b1;
        d.wait_cnt = '0;
      end
    end else begin
      if ((clk_low || bus_idle) && !(rise || fall || start || stop)) begin
        if (q.wait_cnt != '1) begin
          d.wait_cnt = q.wait_cnt + 22'h00_0001;
        end
      end else begin
        d.wait_cnt = '0;
      end
    end

    // the spi modes belong to another port; the serial select pin is never read here
    if (q.ready && q.strap_done && q.mode == srs_pkg::SRS_MODE_TWO_WIRE) begin
      if (q.cfg_sy[3] && ((clk_low && q.wait_cnt == 22'(CLK_LOW_CYC - 1)) ||
                         (bus_idle && q.wait_cnt == 22'(IDLE_CYC - 1)))) begin
        d.st      = SRS_D_IDLE;
        d.sda_oe  = 1'b0;
        d.read_ok = 1'b0;
      end else if (stop) begin
        d.st      = SRS_D_IDLE;
        d.sda_oe  = 1'b0;
        d.read_ok = 1'b0;
      end else if (start) begin
        // a repeated start keeps the pointer and the pointer-set mark
        d.st      = SRS_D_ADDR;
        d.bit_cnt = 4'h0;
        d.sda_oe  = 1'b0;
      end else if (rise) begin
        unique case (q.st)
          SRS_D_ADDR, SRS_D_RX: begin
            d.sh      = {q.sh[6:0], q.sda_sy[1]};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
          SRS_D_TX: begin
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
          SRS_D_TACK: begin
            // a high ninth bit is the last-byte mark; only an ack moves the pointer on
            if (q.sda_sy[1]) begin
              d.st = SRS_D_IDLE;
            end else begin
              d.acked = 1'b1;
              d.ptr   = q.ptr + 8'h01;
            end
          end
          default: ;
        endcase
      end else if (fall) begin
        unique case (q.st)
          SRS_D_ADDR: begin
            if (q.bit_cnt == srs_pkg::SRS_BYTE_BITS) begin
              // a bare read in deep sleep is left unanswered
              if (q.sh[7:1] == q.addr &&
                  !(q.sh[0] && q.cfg_sy[2] && !q.read_ok)) begin
                d.sda_oe = 1'b1;
                d.rw     = q.sh[0];
                d.st     = SRS_D_AACK;
              end else begin
                d.st = SRS_D_IDLE;
              end
            end
          end
          SRS_D_RX: begin
            if (q.bit_cnt == srs_pkg::SRS_BYTE_BITS) begin
              d.sda_oe = 1'b1;
              d.st     = SRS_D_RACK;
              if (q.ptr_phase) begin
                d.ptr       = q.sh;
                d.ptr_phase = 1'b0;
                d.read_ok   = 1'b1;
              end else begin
                d.wdata = q.sh;
                d.wr    = 1'b1;
              end
            end
          end
          SRS_D_RACK: begin
            d.sda_oe  = 1'b0;
            d.st      = SRS_D_RX;
            d.bit_cnt = 4'h0;
          end
          SRS_D_AACK: begin
            if (q.rw) begin
              d.sh     = reg_rdata;
              d.sda_oe = ~reg_rdata[7];
              d.rd     = 1'b1;
              d.st     = SRS_D_TX;
            end else begin
              d.sda_oe    = 1'b0;
              d.st        = SRS_D_RX;
              d.ptr_phase = 1'b1;
            end
            d.bit_cnt = 4'h0;
          end
          SRS_D_TX: begin
            if (q.bit_cnt == srs_pkg::SRS_BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.acked  = 1'b0;
              d.st     = SRS_D_TACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
          SRS_D_TACK: begin
            if (q.acked) begin
              d.sh      = reg_rdata;
              d.sda_oe  = ~reg_rdata[7];
              d.rd      = 1'b1;
              d.st      = SRS_D_TX;
              d.bit_cnt = 4'h0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge lnk.link_clk or posedge reset) begin
    if (reset) begin
      q        <= '0;
      q.scl_sy <= 3'h7;
      q.sda_sy <= 3'h7;
      q.st     <= SRS_D_IDLE;
      q.mode   <= srs_pkg::SRS_MODE_TWO_WIRE;
    end else begin
      q <= d;
    end
  end

  // the clock line has no driver at this end at all, so stretching cannot happen
  assign lnk.sda_out_dev = 1'b0;
  assign lnk.sda_oe_dev  = q.sda_oe;
  assign reg_addr        = q.ptr;
  assign reg_wdata       = q.wdata;
  assign reg_wr          = q.wr;
  assign reg_rd          = q.rd;
  assign protocol_mode   = q.mode;
  assign slave_addr      = q.addr;
  assign link_ready      = q.ready;
endmodule

// ### src/srs_host.sv
// two-wire host end: drives the clock line and sequences register transactions
module srs_host #(
  parameter int POWERUP_CYC = srs_pkg::SRS_HOST_POWERUP_CYC
) (
  srs_link_if.host              lnk,
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  input  wire srs_pkg::srs_op_t cmd_op,
  input  wire logic [6:0]       cmd_dev_addr,
  input  wire logic [7:0]       cmd_reg,
  input  wire logic [7:0]       cmd_len,
  input  wire logic [7:0]       tx_data,
  output logic                  cmd_ready,
  output logic                  tx_take,
  output logic [7:0]            rx_data,
  output logic                  rx_valid,
  output logic                  done,
  output logic                  nack
);
  typedef enum logic [3:0] {
    SRS_H_WAIT   = 4'h0,
    SRS_H_IDLE   = 4'h1,
    SRS_H_START  = 4'h3,
    SRS_H_ADDR   = 4'h2,
    SRS_H_REG    = 4'h6,
    SRS_H_WDATA  = 4'h7,
    SRS_H_RSTART = 4'h5,
    SRS_H_RADDR  = 4'h4,
    SRS_H_RDATA  = 4'hc,
    SRS_H_STOP   = 4'hd
  } srs_host_state_t;

  typedef struct packed {
    logic [1:0]                     scl_sy;
    logic [1:0]                     sda_sy;
    srs_host_state_t                st;
    logic [1:0]                     qtr;
    logic [7:0]                     div;
    logic [3:0]                     bit_cnt;
    logic [7:0]                     sh;
    logic                           ack_n;
    srs_pkg::srs_op_t               op;
    logic [6:0]                     dev_addr;
    logic [7:0]                     reg_b;
    logic [7:0]                     len;
    logic [srs_pkg::SRS_WAIT_W-1:0] wait_cnt;
    logic                           scl_oe;
    logic                           sda_oe;
    logic                           ready;
    logic [7:0]                     rx_data;
    logic                           rx_valid;
    logic                           tx_take;
    logic                           done;
    logic                           nack;
  } srs_host_q_t;

  srs_host_q_t     q;
  srs_host_q_t     d;
  srs_host_state_t ns;
  logic [7:0]      nsh;
  logic            rd_byte;

  always_comb begin
    d          = q;
    d.scl_sy   = {q.scl_sy[0], lnk.scl};
    d.sda_sy   = {q.sda_sy[0], lnk.sda};
    d.rx_valid = 1'b0;
    d.tx_take  = 1'b0;
    d.done     = 1'b0;
    ns         = q.st;
    nsh        = q.sh;
    rd_byte    = (q.st == SRS_H_RDATA);
    if (q.st == SRS_H_WAIT) begin
      // no command leaves until the slave's power-up window has passed
      d.wait_cnt = q.wait_cnt + 22'h00_0001;
      if (q.wait_cnt == 22'(POWERUP_CYC - 1)) begin
        d.st    = SRS_H_IDLE;
        d.ready = 1'b1;
      end
    end else if (q.st == SRS_H_IDLE) begin
      if (cmd_valid && q.ready) begin
        d.ready    = 1'b0;
        d.op       = cmd_op;
        d.dev_addr = cmd_dev_addr;
        d.reg_b    = cmd_reg;
        d.len      = cmd_len;
        d.nack     = 1'b0;
        d.st       = SRS_H_START;
        d.qtr      = 2'h0;
        d.div      = 8'h00;
      end
    end else if (q.qtr == 2'h1 && !q.scl_sy[1]) begin
      // a slave holding the clock low just pauses the high quarter
      d.div = 8'h00;
    end else if (q.div != 8'(srs_pkg::SRS_QTR_CYC - 1)) begin
      d.div = q.div + 8'h01;
    end else begin
      d.div = 8'h00;
      d.qtr = q.qtr + 2'h1;
      unique case (q.qtr)
        2'h0: d.scl_oe = 1'b0;
        2'h1: begin
          if (q.st == SRS_H_START || q.st == SRS_H_RSTART) begin
            d.sda_oe = 1'b1;
          end else if (q.st == SRS_H_STOP) begin
            d.sda_oe = 1'b0;
          end else if (q.bit_cnt == srs_pkg::SRS_BYTE_BITS) begin
            d.ack_n = q.sda_sy[1];
          end else if (rd_byte) begin
            d.sh = {q.sh[6:0], q.sda_sy[1]};
          end
        end
        2'h2: d.scl_oe = (q.st != SRS_H_STOP);
        2'h3: begin
          if (q.st == SRS_H_STOP) begin
            d.st    = SRS_H_IDLE;
            d.ready = 1'b1;
            d.done  = 1'b1;
          end else if (q.st != SRS_H_START && q.st != SRS_H_RSTART &&
                       q.bit_cnt != srs_pkg::SRS_BYTE_BITS) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == srs_pkg::SRS_BYTE_BITS - 4'h1) begin
              // ninth clock: slave answers on writes, host answers on reads
              d.sda_oe = rd_byte && (q.len != 8'h01);
            end else if (!rd_byte) begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end else begin
            unique case (q.st)
              SRS_H_START: begin
                ns  = SRS_H_ADDR;
                nsh = {q.dev_addr, q.op == srs_pkg::SRS_OP_RECEIVE};
              end
              SRS_H_RSTART: begin
                ns  = SRS_H_RADDR;
                nsh = {q.dev_addr, 1'b1};
              end
              SRS_H_ADDR: begin
                ns  = (q.op == srs_pkg::SRS_OP_RECEIVE) ? SRS_H_RDATA : SRS_H_REG;
                nsh = q.reg_b;
              end
              SRS_H_REG: begin
                ns = (q.op == srs_pkg::SRS_OP_WRITE) ? SRS_H_WDATA :
                     (q.op == srs_pkg::SRS_OP_READ) ? SRS_H_RSTART : SRS_H_STOP;
                nsh = tx_data;
                d.tx_take = (q.op == srs_pkg::SRS_OP_WRITE);
              end
              SRS_H_WDATA: begin
                d.len = q.len - 8'h01;
                ns    = (q.len == 8'h01) ? SRS_H_STOP : SRS_H_WDATA;
                nsh   = tx_data;
                d.tx_take = (q.len != 8'h01);
              end
              SRS_H_RADDR: ns = SRS_H_RDATA;
              SRS_H_RDATA: begin
                d.rx_data  = q.sh;
                d.rx_valid = 1'b1;
                d.len      = q.len - 8'h01;
                ns         = (q.len == 8'h01) ? SRS_H_STOP : SRS_H_RDATA;
              end
              default: ns = SRS_H_STOP;
            endcase
            // a refused address or data byte ends the transfer at once
            if (!rd_byte && q.st != SRS_H_START && q.st != SRS_H_RSTART && q.ack_n) begin
              d.nack    = 1'b1;
              ns        = SRS_H_STOP;
              d.tx_take = 1'b0;
            end
            d.st      = ns;
            d.sh      = nsh;
            d.bit_cnt = 4'h0;
            d.sda_oe  = (ns == SRS_H_STOP) ? 1'b1 :
                        (ns == SRS_H_RSTART || ns == SRS_H_RDATA) ? 1'b0 : ~nsh[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q        <= '0;
      q.scl_sy <= 2'h3;
      q.sda_sy <= 2'h3;
      q.st     <= SRS_H_WAIT;
    end else begin
      q <= d;
    end
  end

  assign lnk.scl_out_host = 1'b0;
  assign lnk.scl_oe_host  = q.scl_oe;
  assign lnk.sda_out_host = 1'b0;
  assign lnk.sda_oe_host  = q.sda_oe;
  assign cmd_ready        = q.ready;
  assign tx_take          = q.tx_take;
  assign rx_data          = q.rx_data;
  assign rx_valid         = q.rx_valid;
  assign done             = q.done;
  assign nack             = q.nack;
endmodule

// ### verification/srs_link_checker.sv
// assertions on the two-wire link between host end and register slave end
module srs_link_checker #(
  parameter int POWERUP_CYC = 200
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_dev
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] up_q;
  logic [15:0] oe_q;
  logic [15:0] low_q;
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      up_q <= '0;
      oe_q <= '0;
    end else begin
      up_q <= (up_q < POWERUP_CYC) ? up_q + 32'h1 : up_q;
      oe_q <= sda_oe_dev ? oe_q + 16'h1 : 16'h0;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_q <= '0;
    end else begin
      low_q <= scl ? 16'h0 : low_q + 16'h1;
    end
  end
  quiet_powerup_a: assert property (@(posedge link_clk) disable iff (reset)
    (up_q < POWERUP_CYC) |-> !sda_oe_dev) else $error("device drove data in power-up window");
  pull_low_a: assert property (@(posedge link_clk) disable iff (reset)
    sda_oe_dev |-> !sda) else $error("device pull did not reach the wire");
  data_stable_a: assert property (@(posedge link_clk) disable iff (reset)
    scl && $past(scl) |-> $stable(sda_oe_dev)) else $error("device moved data with clock high");
  start_free_a: assert property (@(posedge link_clk) disable iff (reset)
    $fell(sda) && scl |-> !sda_oe_dev) else $error("device took part in a start");
  stop_release_a: assert property (@(posedge link_clk) disable iff (reset)
    $rose(sda) && scl |=> !sda_oe_dev [*8]) else $error("device drove data after stop");
  hold_max_a: assert property (@(posedge link_clk) disable iff (reset)
    oe_q < 16'h17d4) else $error("device held data longer than one byte");
  clk_slow_a: assert property (@(posedge core_clk) disable iff (reset)
    low_q < 16'd2000) else $error("clock low beyond the slowest rate");
  clk_fast_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(scl) |-> scl [*8]) else $error("clock high too short");
  cover property (@(posedge link_clk) disable iff (reset) $rose(sda_oe_dev));
  cover property (@(posedge link_clk) disable iff (reset) $fell(sda) && scl);
  cover property (@(posedge link_clk) disable iff (reset) $rose(sda) && scl);
endmodule

// ### verification/tb_top.sv
// bench: host end and register slave end joined over the two-wire link
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                core_clk = 0;
  logic                reset = 1;
  logic                cmd_valid = 0;
  srs_pkg::srs_op_t    cmd_op = srs_pkg::SRS_OP_WRITE;
  logic [6:0]          cmd_dev_addr = 7'h2b;
  logic [7:0]          cmd_reg = 8'h00, cmd_len = 8'h01, tx_data = 8'h00;
  srs_pkg::srs_strap_t strap = srs_pkg::SRS_STRAP_R100;
  logic                deep_sleep = 0, tmo_en = 0;
  logic                cmd_ready, tx_take, rx_valid, done, nack, reg_wr, reg_rd, link_ready;
  logic [7:0]          rx_data, reg_addr, reg_wdata, reg_rdata, sh;
  srs_pkg::srs_mode_t  mode;
  logic [6:0]          slave_addr;
  logic [7:0]          regs [256];
  logic [7:0]          wd [4];
  logic [7:0]          rq [$], aq [$];
  logic [15:0]         wq [$];
  int                  widx = 0, bcnt = 0, err_count = 0, checked = 0, rd_cnt = 0;
  srs_link_if lnk();
  initial lnk.link_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  always #7.5 lnk.link_clk = ~lnk.link_clk;
  assign reg_rdata = regs[reg_addr];
  srs_host #(.POWERUP_CYC(100)) i_srs_host (.lnk(lnk.host), .core_clk(core_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg),
    .cmd_len(cmd_len), .tx_data(tx_data), .cmd_ready(cmd_ready), .tx_take(tx_take),
    .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .nack(nack));
  srs_device #(.POWERUP_CYC(200), .CLK_LOW_CYC(400), .IDLE_CYC(100)) i_srs_device (
    .lnk(lnk.device), .reset(reset), .protocol_strap_pin(strap), .timeout_en(tmo_en),
    .deepest_sleep_control(deep_sleep), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .protocol_mode(mode),
    .slave_addr(slave_addr), .link_ready(link_ready));
  srs_link_checker #(.POWERUP_CYC(200)) i_srs_link_checker (.core_clk(core_clk),
    .reset(reset), .link_clk(lnk.link_clk), .scl(lnk.scl), .sda(lnk.sda),
    .sda_oe_dev(lnk.sda_oe_dev));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // register writes land in the bench's register file; any write not noted is a mismatch
  always @(posedge lnk.link_clk) if (reg_wr === 1'b1) begin
    regs[reg_addr] = reg_wdata;
    check("reg_wr", {reg_addr, reg_wdata}, wq.pop_front());
  end
  always @(posedge core_clk) if (rx_valid === 1'b1) begin
    check("rx_data", {8'h00, rx_data}, {8'h00, rq.pop_front()});
  end
  always @(posedge lnk.link_clk) if (reg_rd === 1'b1) rd_cnt++;
  always @(posedge core_clk) if (tx_take === 1'b1) begin
    #2;
    widx = widx + 1;
    tx_data = wd[widx % 4];
  end
  // first byte after each start, seen on the wire, with bit count restarted by the start
  always @(negedge lnk.sda) if (lnk.scl === 1'b1) bcnt = 0;
  always @(posedge lnk.scl) begin
    sh = {sh[6:0], lnk.sda};
    bcnt = bcnt + 1;
    if (bcnt == 8 && aq.size() > 0)
      check("addr_byte", {8'h00, sh}, {8'h00, aq.pop_front()});
  end
  task automatic run(input srs_pkg::srs_op_t op, input logic [6:0] a, input logic [7:0] r,
                     input logic [7:0] l, input logic nk);
    int n;
    n = 0;
    @(posedge core_clk);
    #2;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    cmd_op = op;
    cmd_dev_addr = a;
    cmd_reg = r;
    cmd_len = l;
    cmd_valid = 1;
    @(posedge core_clk);
    #2;
    cmd_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    check("done", {15'h0, done}, 16'h0001);
    check("nack", {15'h0, nack}, {15'h0, nk});
    $display("test op %0d addr %h done", op, a);
  endtask
  initial begin
    #(60000 * 50);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    int st;
    void'($urandom(78474));
    for (int i = 0; i < 256; i++) regs[i] = i[7:0] ^ 8'ha5;
    for (int i = 0; i < 4; i++) wd[i] = 8'($urandom());
    tx_data = wd[0];
    // every strap class, ending on the one used for traffic
    for (int s = 0; s < 9; s++) begin
      st = (s == 8) ? 4 : s;
      strap = srs_pkg::srs_strap_t'(st);
      reset = 1;
      repeat (2) @(posedge core_clk);
      #2 reset = 0;
      repeat (10) @(posedge lnk.link_clk);
      #1;
      check("mode", {14'h0, mode}, 16'((st < 3) ? st + 1 : 0));
      if (st > 2) check("slave_addr", {9'h0, slave_addr}, {9'h0, 4'h5, 3'(7 - st)});
      check("early_ready", {15'h0, link_ready}, 16'h0);
    end
    repeat (300) @(posedge lnk.link_clk);
    check("link_ready", {15'h0, link_ready}, 16'h1);
    wq = '{{8'hfe, wd[0]}, {8'hff, wd[1]}, {8'h00, wd[2]}};
    aq = '{8'h56};
    run(srs_pkg::SRS_OP_WRITE, 7'h2b, 8'hfe, 8'h03, 1'b0);
    rq = '{wd[0], wd[1], wd[2]};
    aq = '{8'h56, 8'h57};
    run(srs_pkg::SRS_OP_READ, 7'h2b, 8'hfe, 8'h03, 1'b0);
    aq = '{8'h56};
    run(srs_pkg::SRS_OP_SET_PTR, 7'h2b, 8'h40, 8'h01, 1'b0);
    rq = '{8'he5};
    aq = '{8'h57};
    run(srs_pkg::SRS_OP_RECEIVE, 7'h2b, 8'h00, 8'h01, 1'b0);
    rq = '{8'he5};
    aq = '{8'h57};
    run(srs_pkg::SRS_OP_RECEIVE, 7'h2b, 8'h00, 8'h01, 1'b0);
    aq = '{8'h58};
    run(srs_pkg::SRS_OP_WRITE, 7'h2c, 8'h10, 8'h01, 1'b1);
    deep_sleep = 1;
    aq = '{8'h57};
    run(srs_pkg::SRS_OP_RECEIVE, 7'h2b, 8'h00, 8'h01, 1'b1);
    deep_sleep = 0;
    // the scaled idle limit is far below a bit's high time, so an enabled idle reset
    // drops the address byte; the pointer must come through it untouched
    tmo_en = 1;
    aq = '{8'h56};
    run(srs_pkg::SRS_OP_WRITE, 7'h2b, 8'h10, 8'h01, 1'b1);
    tmo_en = 0;
    rq = '{8'he5};
    aq = '{8'h57};
    run(srs_pkg::SRS_OP_RECEIVE, 7'h2b, 8'h00, 8'h01, 1'b0);
    check("reg_rd", 16'(rd_cnt), 16'h0006);
    test_done();
  end
endmodule
